/* sinc4_pkg.sv */
package sinc4_pkg;
	// Decimation ratios
	localparam int NOTCH_RATIO      = 256;
	localparam int OUT_RATIO        = 2048;
	localparam int EXT_CLK_DIV      = 20;
	localparam int EXT_CONV_PERIODS = 41036;
	// Internal oscillator sample rates, Hz
	localparam int RATE_50_HZ       = 12800;
	localparam int RATE_5060_HZ     = 13960;
	localparam int RATE_60_HZ       = 15360;
	localparam longint SYS_CLK_HZ   = 250000000;
	// Clock-cycle counts per modulator sample
	localparam int DIV_50   = int'(SYS_CLK_HZ / RATE_50_HZ);
	localparam int DIV_5060 = int'(SYS_CLK_HZ / RATE_5060_HZ);
	localparam int DIV_60   = int'(SYS_CLK_HZ / RATE_60_HZ);
	localparam int ORDER    = 4;
	localparam int DIV_W    = 16;
	// Notch selection codes
	localparam logic [1:0] NOTCH_60   = 2'h0;
	localparam logic [1:0] NOTCH_50   = 2'h1;
	localparam logic [1:0] NOTCH_5060 = 2'h2;
	localparam int FIFO_DEPTH = 16;
endpackage : sinc4_pkg

/* sample_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// Write side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Read side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
	logic [AW:0]      count_ff, nxt_count;
	logic             doWr, doRd;

	assign inReady  = (count_ff != (AW+1)'(DEPTH));
	assign outValid = (count_ff != '0);
	assign outData  = mem_ff[rdPtr_ff];
	assign doWr     = inValid && inReady;
	assign doRd     = outValid && outReady;

	always_comb begin
		nxt_wrPtr = doWr ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
		nxt_rdPtr = doRd ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
		nxt_count = count_ff;
		if (doWr && !doRd) begin
			nxt_count = count_ff + 1'b1;
		end else if (doRd && !doWr) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
		end
	end

	// Storage has no reset; only written cells are ever read
	always_ff @(posedge sys_clk) begin
		if (doWr) begin
			mem_ff[wrPtr_ff] <= inData;
		end
	end
endmodule : sample_fifo
`default_nettype wire

/* sinc4_decimator.sv */
// Overview of operation
// RL1: sample rate is 256 notch, 2048 output
// RL2: internal rates 12800, 13960, 15360 Hz
// RL3: external clock divided by 20
// RL4: fourth-order sinc decimation filter
// RL5: 2x mode skips offset calibration
// RL6: 2x result averages newest two samples
// RL7: running average adds sinc1 notch
// RL8: external conversion lasts 41036 clock periods
// RL9: average sums with extra bit, shifts
`timescale 1ns/1ns
`default_nettype none
module sinc4_decimator
	import sinc4_pkg::*;
#(
	parameter int OUT_W   = 24,
	parameter int ACC_W   = 48,
	parameter int CONV_CNT = EXT_CONV_PERIODS
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// Configuration
	input  wire logic [1:0]       notchSel,
	input  wire logic             speed2x,
	input  wire logic             offsetCalEn,
	input  wire logic             extClkSel,
	// Pins from outside
	input  wire logic             clock_select_pin,
	input  wire logic             modBit,
	// Result stream
	output logic                  resValid,
	input  wire logic             resReady,
	output logic      [OUT_W-1:0] resData,
	output logic                  convBusy,
	output logic                  overflow
);
	logic rstnMeta_ff, rstnSync_ff;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rstnMeta_ff <= 1'b0;
			rstnSync_ff <= 1'b0;
		end else begin
			rstnMeta_ff <= 1'b1;
			rstnSync_ff <= rstnMeta_ff;
		end
	end

	// Three-stage pin synchronisers; change counts when stages 2 and 3 agree
	logic [2:0] extSh_ff, nxt_extSh, bitSh_ff, nxt_bitSh;
	logic       extLvl_ff, nxt_extLvl, bitLvl_ff, nxt_bitLvl;
	always_comb begin
		nxt_extSh  = {extSh_ff[1:0], clock_select_pin};
		nxt_bitSh  = {bitSh_ff[1:0], modBit};
		nxt_extLvl = (extSh_ff[1] == extSh_ff[2]) ? extSh_ff[2] : extLvl_ff;
		nxt_bitLvl = (bitSh_ff[1] == bitSh_ff[2]) ? bitSh_ff[2] : bitLvl_ff;
	end

	// Sample-rate divider: internal oscillator or external clock edges
	logic [DIV_W-1:0] div_ff, nxt_div, divLimit;
	logic [4:0]       extCnt_ff, nxt_extCnt;
	logic             extRise, sampleEn;
	assign extRise = extSh_ff[2] == extSh_ff[1] && extSh_ff[2] && !extLvl_ff;
	always_comb begin
		case (notchSel)
			NOTCH_50:   divLimit = DIV_W'(DIV_50);   // [RL2]
			NOTCH_5060: divLimit = DIV_W'(DIV_5060); // [RL2]
			default:    divLimit = DIV_W'(DIV_60);   // [RL2]
		endcase
		nxt_div    = div_ff;
		nxt_extCnt = extCnt_ff;
		sampleEn   = 1'b0;
		if (extClkSel) begin
			if (extRise) begin
				if (extCnt_ff == 5'(EXT_CLK_DIV - 1)) begin // [RL3]
					nxt_extCnt = '0;
					sampleEn   = 1'b1;
				end else begin
					nxt_extCnt = extCnt_ff + 1'b1;
				end
			end
		end else if (div_ff >= divLimit - 1'b1) begin
			nxt_div  = '0;
			sampleEn = 1'b1;
		end else begin
			nxt_div = div_ff + 1'b1;
		end
	end

	// Fourth-order CIC: integrators at sample rate, combs at output rate
	logic signed [ACC_W-1:0] integ_ff [ORDER], nxt_integ [ORDER];
	logic signed [ACC_W-1:0] combD_ff [ORDER], nxt_combD [ORDER];
	logic signed [ACC_W-1:0] stage [ORDER+1];
	logic [11:0]             decim_ff, nxt_decim;
	logic                    decimEn;
	assign decimEn = sampleEn && decim_ff == 12'(OUT_RATIO - 1); // [RL1]
	always_comb begin
		nxt_decim = sampleEn ? 12'(decimEn ? 0 : decim_ff + 1'b1) : decim_ff;
		nxt_integ = integ_ff;
		nxt_combD = combD_ff;
		if (sampleEn) begin
			// Bitstream maps to +1 / -1
			nxt_integ[0] = integ_ff[0] + (bitLvl_ff ? ACC_W'(1) : -ACC_W'(1));
			for (int i = 1; i < ORDER; i++) begin
				nxt_integ[i] = integ_ff[i] + integ_ff[i-1]; // [RL4]
			end
		end
		stage[0] = integ_ff[ORDER-1];
		for (int i = 0; i < ORDER; i++) begin
			stage[i+1] = stage[i] - combD_ff[i]; // [RL4]
			if (decimEn) begin
				nxt_combD[i] = stage[i];
			end
		end
	end

	// Raw result; wrap-around arithmetic is exact for the CIC
	logic signed [OUT_W-1:0] raw;
	assign raw = stage[ORDER][ACC_W-1 -: OUT_W];

	// Offset calibration: alternate conversions measure offset, 1x only
	logic                    calPhase_ff, nxt_calPhase;
	logic signed [OUT_W-1:0] offs_ff, nxt_offs, prev_ff, nxt_prev;
	logic                    havePrev_ff, nxt_havePrev;
	logic signed [OUT_W:0]   sum;
	logic signed [OUT_W-1:0] res_ff, nxt_res;
	logic                    push;
	assign sum = {raw[OUT_W-1], raw} + {prev_ff[OUT_W-1], prev_ff}; // [RL9]
	always_comb begin
		nxt_calPhase = calPhase_ff;
		nxt_offs     = offs_ff;
		nxt_prev     = prev_ff;
		nxt_havePrev = havePrev_ff;
		nxt_res      = res_ff;
		push         = 1'b0;
		if (decimEn) begin
			if (speed2x) begin
				// No calibration slot so every decimation after the first yields output
				nxt_prev     = raw;                // [RL5]
				nxt_havePrev = 1'b1;
				nxt_calPhase = 1'b0;
				if (havePrev_ff) begin
					nxt_res = OUT_W'(sum >>> 1); // [RL6] [RL7] [RL9]
					push    = 1'b1;
				end
			end else begin
				nxt_havePrev = 1'b0;
				if (offsetCalEn && calPhase_ff) begin
					nxt_offs     = raw;
					nxt_calPhase = 1'b0;
				end else begin
					nxt_res      = OUT_W'(raw - offs_ff);
					nxt_calPhase = offsetCalEn;
					push         = 1'b1;
				end
			end
		end
	end

	// Conversion-phase timer in external clock mode
	localparam int CONV_W = $clog2(CONV_CNT+1);
	logic [CONV_W-1:0]             conv_ff, nxt_conv;
	logic                          ovf_ff, nxt_ovf, fifoReady;
	always_comb begin
		nxt_conv = conv_ff;
		if (extClkSel && extRise) begin
			nxt_conv = (conv_ff == CONV_W'(CONV_CNT - 1)) ? '0 :
				CONV_W'(conv_ff + 1'b1); // [RL8]
		end
		// Sticky flag; result dropped when nobody drains the queue
		nxt_ovf = ovf_ff || (push && !fifoReady);
	end
	assign convBusy = extClkSel ? (conv_ff != '0) : (decim_ff != '0);
	assign overflow = ovf_ff;

	always_ff @(posedge sys_clk or negedge rstnSync_ff) begin
		if (!rstnSync_ff) begin
			extSh_ff    <= '0;
			bitSh_ff    <= '0;
			extLvl_ff   <= 1'b0;
			bitLvl_ff   <= 1'b0;
			div_ff      <= '0;
			extCnt_ff   <= '0;
			decim_ff    <= '0;
			for (int i = 0; i < ORDER; i++) begin
				integ_ff[i] <= '0;
				combD_ff[i] <= '0;
			end
			calPhase_ff <= 1'b0;
			offs_ff     <= '0;
			prev_ff     <= '0;
			havePrev_ff <= 1'b0;
			res_ff      <= '0;
			conv_ff     <= '0;
			ovf_ff      <= 1'b0;
		end else begin
			extSh_ff    <= nxt_extSh;
			bitSh_ff    <= nxt_bitSh;
			extLvl_ff   <= nxt_extLvl;
			bitLvl_ff   <= nxt_bitLvl;
			div_ff      <= nxt_div;
			extCnt_ff   <= nxt_extCnt;
			decim_ff    <= nxt_decim;
			integ_ff    <= nxt_integ;
			combD_ff    <= nxt_combD;
			calPhase_ff <= nxt_calPhase;
			offs_ff     <= nxt_offs;
			prev_ff     <= nxt_prev;
			havePrev_ff <= nxt_havePrev;
			res_ff      <= nxt_res;
			conv_ff     <= nxt_conv;
			ovf_ff      <= nxt_ovf;
		end
	end

	// Push one cycle after the result register loads
	logic pushD_ff, nxt_pushD;
	assign nxt_pushD = push;
	always_ff @(posedge sys_clk or negedge rstnSync_ff) begin
		if (!rstnSync_ff) begin
			pushD_ff <= 1'b0;
		end else begin
			pushD_ff <= nxt_pushD;
		end
	end

	sample_fifo #(
		.WIDTH (OUT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.rstn     (rstnSync_ff),
		.inValid  (pushD_ff),
		.inReady  (fifoReady),
		.inData   (res_ff),
		.outValid (resValid),
		.outReady (resReady),
		.outData  (resData)
	);
endmodule : sinc4_decimator
`default_nettype wire

/* sinc4_decimator_chk_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module sinc4_decimator_chk #(
	parameter int OUT_W = 24
) (
	// Clock and reset
	input wire logic             sys_clk,
	input wire logic             rstn,
	// Configuration and pins
	input wire logic [1:0]       notchSel,
	input wire logic             speed2x,
	input wire logic             offsetCalEn,
	input wire logic             extClkSel,
	input wire logic             clock_select_pin,
	input wire logic             modBit,
	// Result stream
	input wire logic             resValid,
	input wire logic             resReady,
	input wire logic [OUT_W-1:0] resData,
	input wire logic             convBusy,
	input wire logic             overflow
);
	logic [18:0] upCnt_ff, nxt_upCnt;
	logic        only2x_ff, nxt_only2x, allHigh_ff, nxt_allHigh;
	always_comb begin
		nxt_upCnt = (upCnt_ff == 19'h7FFFF) ? upCnt_ff : upCnt_ff + 19'h1;
		nxt_only2x = only2x_ff & speed2x;
		nxt_allHigh = allHigh_ff & modBit;
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			upCnt_ff <= 19'h0;
			only2x_ff <= 1'b1;
			allHigh_ff <= 1'b1;
		end else begin
			upCnt_ff <= nxt_upCnt;
			only2x_ff <= nxt_only2x;
			allHigh_ff <= nxt_allHigh;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Pin filter needs two cycles per level: a rise every 4, 20 per sample
	property p_min_gap; resValid |-> upCnt_ff >= 19'h28000; endproperty
	a_min_gap: assert property (p_min_gap)
		else $error("result earlier than one full decimation");
	// First raw in 2x gives nothing, so two conversions are needed
	property p_first2x;
		resValid && only2x_ff |-> upCnt_ff >= 19'h50000;
	endproperty
	a_first2x: assert property (p_first2x)
		else $error("2x result before two raw samples");
	property p_sign; resValid && allHigh_ff |-> !resData[OUT_W-1]; endproperty
	a_sign: assert property (p_sign)
		else $error("all-ones bitstream gave negative result");
	property p_hold_data; resValid && !resReady |=> $stable(resData); endproperty
	a_hold_data: assert property (p_hold_data)
		else $error("result changed while not taken");
	property p_hold_valid; resValid && !resReady |=> resValid; endproperty
	a_hold_valid: assert property (p_hold_valid)
		else $error("valid dropped while not taken");
	property p_valid_fall; $fell(resValid) |-> $past(resReady); endproperty
	a_valid_fall: assert property (p_valid_fall)
		else $error("valid fell without a take");
	property p_ovf_sticky; overflow |=> overflow; endproperty
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("overflow cleared outside reset");
	property p_rst_clear; $rose(rstn) |-> !resValid && !overflow && !convBusy; endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("outputs not clear at reset release");
endmodule : sinc4_decimator_chk
bind sinc4_decimator sinc4_decimator_chk #(.OUT_W(OUT_W)) chk (.*);
`default_nettype wire

/* mod_stream_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mod_stream_model (
	// Clock and control
	input  wire logic sys_clk,
	input  wire logic run,
	input  wire logic level,
	// Pins toward the converter
	output logic      extClk,
	output logic      bitOut
);
	// Conversion clock stands low between frames
	// Each level lasts two cycles so the pin filter sees both stages agree
	logic phase;
	initial extClk = 1'b0;
	initial phase = 1'b0;
	always @(negedge sys_clk) begin
		if (!run) begin
			extClk <= 1'b0;
			phase  <= 1'b0;
		end else begin
			phase <= ~phase;
			if (phase) begin
				extClk <= ~extClk;
			end
		end
	end
	assign bitOut = level;
endmodule : mod_stream_model
`default_nettype wire

/* tb_sinc4_decimator.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_sinc4_decimator;
	import sinc4_pkg::*;
	logic        sys_clk = 1'b0, rstn = 1'b0, run = 1'b0, level = 1'b1;
	logic [1:0]  notchSel = NOTCH_60;
	logic        speed2x = 1'b0, offsetCalEn = 1'b0, extClkSel = 1'b1;
	logic        resReady = 1'b0;
	logic        extClk, modBit, resValid, convBusy, overflow;
	logic [23:0] resData, held;
	int          error_cnt = 0, cmp_count = 0, n;
	always #2 sys_clk = ~sys_clk;
	mod_stream_model part (.sys_clk(sys_clk), .run(run), .level(level),
		.extClk(extClk), .bitOut(modBit));
	sinc4_decimator #(.CONV_CNT(40)) dut (.sys_clk(sys_clk), .rstn(rstn),
		.notchSel(notchSel), .speed2x(speed2x), .offsetCalEn(offsetCalEn),
		.extClkSel(extClkSel), .clock_select_pin(extClk), .modBit(modBit),
		.resValid(resValid), .resReady(resReady), .resData(resData),
		.convBusy(convBusy), .overflow(overflow));
	task check(input logic [23:0] seen, input logic [23:0] exp, input string m);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s", $time, m);
		end
	endtask : check
	task tally_and_finish;
		$display("Errors %0d, comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task t_reset;
		repeat (4) @(negedge sys_clk);
		check({resValid, convBusy, overflow}, 24'h0, "outputs in reset");
		rstn = 1'b1;
	endtask : t_reset
	// One external-clock conversion, 1x, consumer stalls first
	task t_conversion;
		run = 1'b1;
		n = 0;
		while (!convBusy && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		check(convBusy, 1'b1, "no conversion started");
		n = 0;
		while (!resValid && n < 200000) begin
			@(negedge sys_clk);
			n++;
		end
		check(n >= 163800, 1'b1, "result too early");
		check(resValid, 1'b1, "no result");
		check(resData[23], 1'b0, "full-scale sign");
		check(resData == 24'h0, 1'b0, "full-scale zero");
		held = resData;
		repeat (6) @(negedge sys_clk);
		check(resData, held, "data held while stalled");
		resReady = 1'b1;
		@(negedge sys_clk);
		resReady = 1'b0;
		repeat (2) @(negedge sys_clk);
		check(resValid, 1'b0, "word not drained");
		check(overflow, 1'b0, "spurious overflow");
		run = 1'b0;
	endtask : t_conversion
	initial begin
		#(4 * 200000);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		t_reset();
		t_conversion();
		tally_and_finish();
	end
endmodule : tb_sinc4_decimator
`default_nettype wire
